// file: hw/exc_pkg.sv
/*
 * constants shared by the exception priority model: exception numbers,
 * register offsets, field positions, reset values and vector addresses.
 * assumes a 32-bit apb register bus with 8 address bits decoded.
 */
package exc_pkg;
  // sizes
  localparam int NUM_EXC = 42; // exception numbers 0..41
  localparam int NUM_IRQ = 26; // peripheral request lines
  localparam int IRQ_BASE = 16; // exception number of line 0
  localparam int PRIO_W = 3; // eight levels
  localparam int NUM_W = 6; // exception number width
  localparam int ADDR_W = 8; // decoded apb address bits
  localparam int NUM_SYS = 7; // system handlers with a level

  // exception numbers
  localparam int EXC_NMI = 2;
  localparam int EXC_HF = 3;
  localparam int EXC_MM = 4;
  localparam int EXC_BF = 5;
  localparam int EXC_UF = 6;
  localparam int EXC_SVC = 11;
  localparam int EXC_DBG = 12;
  localparam int EXC_PSV = 14;
  localparam int EXC_TICK = 15;
  // system handlers in field order of the priority and enable words
  localparam int SYS_NUM [NUM_SYS] = '{4, 5, 6, 11, 12, 14, 15};

  // masks over exception numbers
  localparam logic [NUM_EXC-1:0] FIXED_MASK = 42'h000_0000_000C;
  localparam logic [NUM_EXC-1:0] SYNC_MASK = 42'h000_0000_0870;

  // rank values
  localparam logic [3:0] RANK_NMI = 4'h1;
  localparam logic [3:0] RANK_HF = 4'h2;
  localparam logic [3:0] RANK_CFG0 = 4'h3; // level 0 ranks third
  localparam logic [3:0] RANK_IDLE = 4'hF; // thread, nothing active

  // vector table
  localparam logic [31:0] RESET_SP_ADDR = 32'h0000_0000;
  localparam logic [31:0] RESET_PC_ADDR = 32'h0000_0004;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL_STATE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_HND_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SYS_PRIO = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_SET_EN = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DISABLE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SET_PEND = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CLR_PEND = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_ACTIVE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_FAULT = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_PRIO0 = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_PRIO_END = 8'h44;

  // control and state word fields
  localparam int CS_NMI_SET = 31;
  localparam int CS_PSV_SET = 28;
  localparam int CS_PSV_CLR = 27;
  localparam int CS_TICK_SET = 26;
  localparam int CS_TICK_CLR = 25;
  localparam int CS_PEND_LSB = 12;
  localparam int CS_CUR_LSB = 0;
  // handler control word: enable of handler k at bit HC_EN_LSB + k
  localparam int HC_EN_LSB = 16;
  // config word fields
  localparam int CFG_SUB_LSB = 0; // two bits: subpriority width
  localparam int CFG_UNALIGN = 2;
  localparam int CFG_DIV0 = 3;
  localparam int CFG_PROT_EN = 4;
  localparam int CFG_TICK_INT = 5;
  localparam int CFG_W = 6;
  // fault status fields
  localparam int FS_BF_PRECISE = 0;
  localparam int FS_BF_IMPRECISE = 1;
  localparam int FS_XN_FETCH = 2;
  localparam int FS_ENTRY_ERR = 3;
  localparam int FS_W = 4;
  // priority field strides
  localparam int SYS_STRIDE = 4;
  localparam int IRQ_STRIDE = 8;

  // reset values
  localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;
  localparam logic [NUM_EXC-1:0] EN_RST = 42'h000_0000_0000;
  localparam logic [CFG_W-1:0] CFG_RST = 6'h00;
endpackage

// file: hw/exception_priority_model.sv
/*
 * exception priority model: tracks pending and active state of every
 * exception, ranks them by fixed and programmable level, and steers the
 * pipeline through boot, entry, tail-chain and return.
 * assumes apb with psel/penable/pready, request inputs synchronous to
 * pclk, and a pipeline that answers entry_done, unstack_done, boot_done.
 */
module exception_priority_model
  import exc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [exc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // request sources
  input wire logic nmi_pin,
  input wire logic [exc_pkg::NUM_IRQ-1:0] irq_lines,
  input wire logic prot_violation,
  input wire logic xn_fetch,
  input wire logic bus_err_precise,
  input wire logic bus_err_imprecise,
  input wire logic undef_instr,
  input wire logic unaligned_illegal,
  input wire logic invalid_state,
  input wire logic bad_return,
  input wire logic unaligned_access,
  input wire logic div_zero,
  input wire logic svc_exec,
  input wire logic dbg_req,
  input wire logic halting,
  input wire logic tick_zero,
  input wire logic entry_err,
  // pipeline side
  input wire logic boot_done,
  input wire logic entry_done,
  input wire logic exc_return,
  input wire logic [exc_pkg::NUM_W-1:0] ret_num,
  input wire logic unstack_done,
  output logic sp_load,
  output logic vec_fetch,
  output logic [31:0] vec_addr,
  output logic stack_push,
  output logic unstack,
  output logic [exc_pkg::NUM_W-1:0] exc_num,
  output logic handler_mode,
  output logic fetch_abort
);
  import exc_pkg::*;

  typedef enum logic [2:0] {
    ST_BOOT_SP, ST_BOOT_PC, ST_RUN, ST_ENTRY, ST_TAIL, ST_UNSTACK
  } state_t;

  // all state of the block
  typedef struct packed {
    state_t st;
    logic [NUM_EXC-1:0] pend; // pending per exception number
    logic [NUM_EXC-1:0] act; // active per exception number
    logic [NUM_EXC-1:0] en; // software enables
    logic [NUM_EXC-1:0][PRIO_W-1:0] prio; // programmable levels
    logic [CFG_W-1:0] cfg;
    logic [FS_W-1:0] fsr; // sticky fault causes
    logic [NUM_W-1:0] cur; // last exception taken
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic sp_load;
    logic vec_fetch;
    logic stack_push;
    logic unstack;
    logic handler_mode;
    logic fetch_abort;
    logic [31:0] vec_addr;
  } regs_t;

  regs_t q, d;

  // arbiter results, shared by the state update and the checks
  logic [NUM_EXC-1:0] en_eff; // enables with fixed ones forced on
  logic [NUM_EXC-1:0] act_eff; // active after this cycle's return
  logic [NUM_W-1:0] cand_num; // best eligible pending exception
  logic cand_valid;
  logic [3:0] cand_grp; // its preemption rank
  logic [3:0] run_grp; // rank of the running context
  logic take_now;

  // rank of exception i; sub bits dropped for the preemption view
  function automatic logic [3:0] grp_of(input int i,
      input logic [PRIO_W-1:0] p, input logic [1:0] s);
    if (i == EXC_NMI) begin
      return RANK_NMI;
    end
    if (i == EXC_HF) begin
      return RANK_HF;
    end
    return 4'(p >> s) + RANK_CFG0;
  endfunction

  // arbiter: lowest rank wins, ascending scan keeps lowest number
  always_comb begin
    logic [3:0] best;
    logic [3:0] g;
    best = RANK_IDLE;
    g = RANK_IDLE;
    en_eff = q.en | FIXED_MASK;
    act_eff = q.act;
    if (q.st == ST_RUN && exc_return && ret_num < NUM_W'(NUM_EXC)) begin
      act_eff[ret_num] = 1'b0;
    end
    cand_num = '0;
    cand_valid = 1'b0;
    cand_grp = RANK_IDLE;
    run_grp = RANK_IDLE;
    for (int i = 0; i < NUM_EXC; i++) begin
      g = grp_of(i, q.prio[i], q.cfg[CFG_SUB_LSB +: 2]);
      if (act_eff[i] && g < run_grp) begin
        run_grp = g;
      end
      // debug monitor waits while the core halts
      if (q.pend[i] && en_eff[i] && !(i == EXC_DBG && halting) &&
          grp_of(i, q.prio[i], 2'h0) < best) begin
        best = grp_of(i, q.prio[i], 2'h0);
        cand_num = NUM_W'(i);
        cand_grp = g;
        cand_valid = 1'b1;
      end
    end
    // strictly higher preemption rank needed to interrupt
    take_now = q.st == ST_RUN && cand_valid &&
        cand_grp < run_grp;
  end

  // next state of everything
  always_comb begin
    logic wr;
    logic setup;
    logic unm;
    logic esc;
    logic [NUM_EXC-1:0] set_v;
    logic [NUM_EXC-1:0] clr_v;
    logic [31:0] rdat;
    int w;
    wr = psel && penable && pwrite && q.pready;
    setup = psel && !penable;
    unm = 1'b0;
    esc = 1'b0;
    set_v = '0;
    clr_v = '0;
    rdat = '0;
    w = 0;
    d = q;
    // hardware request sources
    set_v[EXC_NMI] = nmi_pin;
    set_v[EXC_HF] = entry_err;
    set_v[EXC_MM] = (prot_violation && q.cfg[CFG_PROT_EN]) ||
        xn_fetch;
    set_v[EXC_BF] = bus_err_precise || bus_err_imprecise;
    set_v[EXC_UF] = undef_instr || unaligned_illegal || invalid_state ||
        bad_return || (unaligned_access && q.cfg[CFG_UNALIGN]) ||
        (div_zero && q.cfg[CFG_DIV0]);
    set_v[EXC_SVC] = svc_exec;
    set_v[EXC_DBG] = dbg_req && en_eff[EXC_DBG] && !halting;
    set_v[EXC_TICK] = tick_zero && q.cfg[CFG_TICK_INT];
    set_v[IRQ_BASE +: NUM_IRQ] = irq_lines;
    // register writes, taken at the access edge
    if (wr) begin
      case (paddr)
        OFS_CTRL_STATE: begin
          set_v[EXC_NMI] = set_v[EXC_NMI] | pwdata[CS_NMI_SET];
          set_v[EXC_PSV] = pwdata[CS_PSV_SET];
          clr_v[EXC_PSV] = pwdata[CS_PSV_CLR];
          set_v[EXC_TICK] = set_v[EXC_TICK] | pwdata[CS_TICK_SET];
          clr_v[EXC_TICK] = pwdata[CS_TICK_CLR];
        end
        OFS_HND_CTRL: begin
          for (int k = 0; k < NUM_SYS; k++) begin
            d.en[SYS_NUM[k]] = pwdata[HC_EN_LSB + k];
          end
        end
        OFS_CFG: d.cfg = pwdata[CFG_W-1:0];
        OFS_SYS_PRIO: begin
          for (int k = 0; k < NUM_SYS; k++) begin
            d.prio[SYS_NUM[k]] = pwdata[SYS_STRIDE*k +: PRIO_W];
          end
        end
        OFS_SET_EN: d.en[IRQ_BASE +: NUM_IRQ] =
            q.en[IRQ_BASE +: NUM_IRQ] | pwdata[NUM_IRQ-1:0];
        OFS_DISABLE: d.en[IRQ_BASE +: NUM_IRQ] =
            q.en[IRQ_BASE +: NUM_IRQ] & ~pwdata[NUM_IRQ-1:0];
        OFS_SET_PEND: set_v[IRQ_BASE +: NUM_IRQ] =
            irq_lines | pwdata[NUM_IRQ-1:0];
        OFS_CLR_PEND: clr_v[IRQ_BASE +: NUM_IRQ] = pwdata[NUM_IRQ-1:0];
        OFS_FAULT: d.fsr = q.fsr & ~pwdata[FS_W-1:0];
        default: begin
          // four line levels per word, one byte each
          if (paddr >= OFS_PRIO0 && paddr < OFS_PRIO_END) begin
            w = int'(paddr - OFS_PRIO0) / 4;
            for (int b = 0; b < 4; b++) begin
              if (4 * w + b < NUM_IRQ) begin
                d.prio[IRQ_BASE + 4 * w + b] =
                    pwdata[IRQ_STRIDE*b +: PRIO_W];
              end
            end
          end
        end
      endcase
    end
    // synchronous faults that are disabled escalate to hard fault
    esc = |(set_v & SYNC_MASK & ~en_eff);
    set_v = set_v & ~(SYNC_MASK & ~en_eff);
    set_v[EXC_HF] = set_v[EXC_HF] | esc;
    // sticky fault causes; a new cause beats a clear
    d.fsr = d.fsr | {entry_err, xn_fetch, bus_err_imprecise,
        bus_err_precise};
    d.fetch_abort = xn_fetch;
    // pipeline sequencing
    case (q.st)
      ST_BOOT_SP: begin
        if (boot_done) begin
          d.st = ST_BOOT_PC;
          d.sp_load = 1'b0;
          d.vec_fetch = 1'b1;
          d.vec_addr = RESET_PC_ADDR;
        end
      end
      ST_BOOT_PC: begin
        if (boot_done) begin
          d.st = ST_RUN; // privileged thread mode
          d.vec_fetch = 1'b0;
        end
      end
      ST_RUN: begin
        d.act = act_eff;
        // registered take lets one more instruction retire
        if (take_now) begin
          d.st = exc_return ? ST_TAIL : ST_ENTRY;
          d.stack_push = !exc_return;
          d.vec_fetch = 1'b1;
          d.cur = cand_num;
          d.vec_addr = 32'({cand_num, 2'b00});
          d.act[cand_num] = 1'b1;
          clr_v[cand_num] = 1'b1;
        end else if (exc_return) begin
          d.st = ST_UNSTACK;
          d.unstack = 1'b1;
        end
      end
      ST_ENTRY, ST_TAIL: begin
        if (entry_done) begin
          d.st = ST_RUN;
          d.stack_push = 1'b0;
          d.vec_fetch = 1'b0;
        end
      end
      ST_UNSTACK: begin
        if (unstack_done) begin
          d.st = ST_RUN;
          d.unstack = 1'b0;
        end
      end
      default: d.st = ST_BOOT_SP;
    endcase
    // a level still high when taken pends again at once
    d.pend = (q.pend & ~clr_v) | set_v;
    d.handler_mode = |d.act;
    // read data prepared in the setup cycle
    case (paddr)
      OFS_CTRL_STATE: begin
        rdat[CS_NMI_SET] = q.pend[EXC_NMI];
        rdat[CS_PSV_SET] = q.pend[EXC_PSV];
        rdat[CS_TICK_SET] = q.pend[EXC_TICK];
        rdat[CS_PEND_LSB +: NUM_W] = cand_num;
        rdat[CS_CUR_LSB +: NUM_W] = q.cur;
      end
      OFS_HND_CTRL: begin
        for (int k = 0; k < NUM_SYS; k++) begin
          rdat[HC_EN_LSB + k] = q.en[SYS_NUM[k]];
        end
      end
      OFS_CFG: rdat[CFG_W-1:0] = q.cfg;
      OFS_SYS_PRIO: begin
        for (int k = 0; k < NUM_SYS; k++) begin
          rdat[SYS_STRIDE*k +: PRIO_W] = q.prio[SYS_NUM[k]];
        end
      end
      OFS_SET_EN, OFS_DISABLE: rdat[NUM_IRQ-1:0] =
          q.en[IRQ_BASE +: NUM_IRQ];
      OFS_SET_PEND, OFS_CLR_PEND: rdat[NUM_IRQ-1:0] =
          q.pend[IRQ_BASE +: NUM_IRQ];
      OFS_ACTIVE: rdat[NUM_IRQ-1:0] = q.act[IRQ_BASE +: NUM_IRQ];
      OFS_FAULT: rdat[FS_W-1:0] = q.fsr;
      default: begin
        if (paddr >= OFS_PRIO0 && paddr < OFS_PRIO_END &&
            paddr[1:0] == 2'h0) begin
          w = int'(paddr - OFS_PRIO0) / 4;
          for (int b = 0; b < 4; b++) begin
            if (4 * w + b < NUM_IRQ) begin
              rdat[IRQ_STRIDE*b +: PRIO_W] = q.prio[IRQ_BASE + 4 * w + b];
            end
          end
        end else begin
          unm = 1'b1;
        end
      end
    endcase
    // one wait-free answer: ready in the first access cycle
    d.pready = setup;
    if (setup) begin
      d.prdata = pwrite ? 32'h0000_0000 : rdat;
      d.pslverr = unm;
    end
  end

  // state register; reset drops everything mid-instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= ST_BOOT_SP;
      q.en <= EN_RST;
      q.prio <= {NUM_EXC{PRIO_RST}};
      q.cfg <= CFG_RST;
      q.sp_load <= 1'b1;
      q.vec_addr <= RESET_SP_ADDR;
    end else begin
      q <= d;
    end
  end

  assign pready = q.pready;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign sp_load = q.sp_load;
  assign vec_fetch = q.vec_fetch;
  assign vec_addr = q.vec_addr;
  assign stack_push = q.stack_push;
  assign unstack = q.unstack;
  assign exc_num = q.cur;
  assign handler_mode = q.handler_mode;
  assign fetch_abort = q.fetch_abort;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_prio_reset_zero: assert property (disable iff (1'b0)
      $rose(presetn) |-> q.prio == '0 && q.sp_load)
    else $error("levels not zero after reset");
  a_boot_stack_first: assert property (
      q.st == ST_BOOT_SP |-> q.sp_load && q.vec_addr == RESET_SP_ADDR)
    else $error("boot not loading stack pointer from entry 0");
  a_boot_pc_vec: assert property (
      q.st == ST_BOOT_SP && boot_done |=>
      q.vec_fetch && q.vec_addr == RESET_PC_ADDR)
    else $error("boot not fetching reset vector");
  a_nmi_wins: assert property (
      q.st == ST_RUN && q.pend[EXC_NMI] && !q.act[EXC_NMI] |=>
      q.cur == NUM_W'(EXC_NMI) && q.act[EXC_NMI])
    else $error("pending nmi not taken");
  a_entry_parallel: assert property (
      q.st == ST_RUN && take_now && !exc_return |=>
      q.stack_push && q.vec_fetch && q.vec_addr == 32'({q.cur, 2'b00}))
    else $error("entry without stacking and fetch together");
  a_tail_no_stack: assert property (
      take_now && exc_return |=> q.st == ST_TAIL && !q.stack_push &&
      !q.unstack && q.vec_fetch)
    else $error("tail chain restacked");
  a_preempt_keeps: assert property (
      take_now && !exc_return && q.handler_mode |=>
      $countones(q.act) == $countones($past(q.act)) + 1)
    else $error("preempted handler lost active state");
  a_take_grp: assert property (
      take_now |-> cand_grp < run_grp && en_eff[cand_num])
    else $error("take without higher preemption rank");
  a_xn_abort: assert property (
      xn_fetch |=> q.fetch_abort && q.pend[EXC_MM] | q.pend[EXC_HF])
    else $error("execute-never fetch not aborted");
  a_dbg_halted: assert property (
      halting && q.st == ST_RUN |-> !(take_now &&
      cand_num == NUM_W'(EXC_DBG)))
    else $error("debug monitor taken while halting");
  a_apb_answer: assert property (
      psel && !penable |=> q.pready ##1 !q.pready)
    else $error("apb answer not in first access cycle");
endmodule // exception_priority_model

// file: bench/pipeline_model.sv
/*
 * pipeline model: answers boot loads, exception entries and unstacking
 * with one done pulse after a set number of cycles.
 * assumes level requests from the block that drop after each pulse.
 */
module pipeline_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] lat,
  input wire logic sp_load,
  input wire logic vec_fetch,
  input wire logic unstack,
  input wire logic handler_mode,
  output logic boot_done,
  output logic entry_done,
  output logic unstack_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_q; // cycles spent on the current request
  logic cool_q; // idle cycle while the request drops
  // lat sets prompt or slow answers; done pulses last one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_done <= 1'b0;
      entry_done <= 1'b0;
      unstack_done <= 1'b0;
      cool_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      boot_done <= 1'b0;
      entry_done <= 1'b0;
      unstack_done <= 1'b0;
      if (cool_q) begin
        cool_q <= 1'b0;
      end else if (sp_load | vec_fetch | unstack) begin
        if (cnt_q >= lat) begin
          cool_q <= 1'b0 | 1'b1;
          cnt_q <= 4'h0;
          if (unstack) unstack_done <= 1'b1;
          else if (!handler_mode) boot_done <= 1'b1;
          else entry_done <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule // pipeline_model

// file: bench/exception_priority_model_tb.sv
/*
 * testbench: apb register access, boot, entry, preemption, tail-chain
 * and fault escalation of the exception priority model.
 * assumes the pipeline model answers every request of the block.
 */
module exception_priority_model_tb;
  import exc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, vec_addr;
  logic nmi_pin, exc_return, dbg_req, halting, tick_zero;
  logic [25:0] irq_lines;
  logic [11:0] flt; // fault and call sources, one bit each
  logic [5:0] ret_num, exc_num;
  logic [3:0] lat; // partner answer delay
  logic boot_done, entry_done, unstack_done, sp_load, vec_fetch;
  logic stack_push, unstack, handler_mode, fetch_abort;
  int mismatches, num_checks, k;

  exception_priority_model exception_priority_model_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .nmi_pin(nmi_pin),
    .irq_lines(irq_lines), .prot_violation(flt[9]),
    .xn_fetch(flt[8]), .bus_err_precise(flt[4]),
    .bus_err_imprecise(flt[5]), .undef_instr(flt[0]),
    .unaligned_illegal(flt[1]), .invalid_state(flt[2]),
    .bad_return(flt[3]), .unaligned_access(flt[10]),
    .div_zero(flt[11]), .svc_exec(flt[7]), .dbg_req(dbg_req),
    .halting(halting), .tick_zero(tick_zero), .entry_err(flt[6]),
    .boot_done(boot_done), .entry_done(entry_done),
    .exc_return(exc_return), .ret_num(ret_num),
    .unstack_done(unstack_done), .sp_load(sp_load),
    .vec_fetch(vec_fetch), .vec_addr(vec_addr),
    .stack_push(stack_push), .unstack(unstack), .exc_num(exc_num),
    .handler_mode(handler_mode), .fetch_abort(fetch_abort));

  pipeline_model pipeline_model_inst (
    .pclk(pclk), .presetn(presetn), .lat(lat), .sp_load(sp_load),
    .vec_fetch(vec_fetch), .unstack(unstack),
    .handler_mode(handler_mode), .boot_done(boot_done),
    .entry_done(entry_done), .unstack_done(unstack_done));

  // free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // one comparison, counted; reports at once on a difference
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one apb transfer; read data kept in rd
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      #1;
      if (pready === 1'b1) break;
      @(posedge pclk);
    end
    if (i == 20) check(32'h0, 32'h1);
    // request held until the edge that samples pready; answer taken there
    @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // 0: fetch seen, 1: unstack seen, 2: pipeline idle; bounded
  task wait_on(input int w);
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge pclk);
      #1;
      if (w == 0 && vec_fetch === 1'b1) break;
      if (w == 1 && unstack === 1'b1) break;
      if (w == 2 && vec_fetch !== 1'b1 && unstack !== 1'b1 &&
          sp_load !== 1'b1) break;
    end
    if (i == 60) check(32'h0, 32'h1);
  endtask

  // entry of exception n: number, vector, stacking, mode
  task ent(input int n, input logic push);
    wait_on(0);
    check(32'(exc_num), 32'(n));
    check(vec_addr, 32'(n * 4));
    check(32'(stack_push), 32'(push));
    check(32'(handler_mode), 32'h1);
    wait_on(2);
  endtask

  // handler return pulse; back() also waits out the unstack
  task rtn(input int n);
    @(posedge pclk);
    exc_return <= 1'b1;
    ret_num <= 6'(n);
    @(posedge pclk);
    exc_return <= 1'b0;
  endtask

  task back(input int n);
    rtn(n);
    wait_on(1);
    wait_on(2);
  endtask

  // watchdog well past the expected run length
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, nmi_pin, exc_return} = 6'h0;
    {dbg_req, halting, tick_zero} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    irq_lines = 26'h0;
    flt = 12'h000;
    ret_num = 6'h00;
    lat = 4'h1;
    repeat (8) @(posedge pclk);
    #1;
    check(32'(sp_load), 32'h1);
    check(vec_addr, RESET_SP_ADDR);
    @(posedge pclk);
    presetn <= 1'b1;
    wait_on(0);
    check(vec_addr, RESET_PC_ADDR);
    check(32'(handler_mode), 32'h0);
    wait_on(2);
    $display("test boot done");
    // levels reset to zero; each field holds three bits
    rd_chk(OFS_SYS_PRIO, 32'h0);
    for (k = 32'(OFS_PRIO0); k < 32'(OFS_PRIO_END); k += 4)
      rd_chk(8'(k), 32'h0);
    apb(1'b1, OFS_PRIO0, 32'hFFFFFFFF);
    rd_chk(OFS_PRIO0, 32'h07070707);
    apb(1'b1, OFS_SYS_PRIO, 32'hFFFFFFFF);
    rd_chk(OFS_SYS_PRIO, 32'h07777777);
    apb(1'b1, OFS_PRIO0, 32'h0);
    apb(1'b1, OFS_SYS_PRIO, 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    check(rd, 32'h0);
    check(32'(err), 32'h1);
    $display("test registers done");
    // peripheral entry, then nmi preempts it
    apb(1'b1, OFS_SET_EN, 32'h1);
    @(posedge pclk);
    irq_lines[0] <= 1'b1;
    ent(IRQ_BASE, 1'b1);
    irq_lines[0] <= 1'b0;
    apb(1'b1, OFS_CLR_PEND, 32'h1);
    @(posedge pclk);
    nmi_pin <= 1'b1;
    @(posedge pclk);
    nmi_pin <= 1'b0;
    ent(EXC_NMI, 1'b1);
    rd_chk(OFS_ACTIVE, 32'h1);
    back(EXC_NMI);
    check(32'(handler_mode), 32'h1);
    back(IRQ_BASE);
    check(32'(handler_mode), 32'h0);
    $display("test preempt done");
    // equal levels, lowest number first, then tail-chain
    lat <= 4'h5;
    apb(1'b1, OFS_SET_EN, 32'h6);
    apb(1'b1, OFS_SET_PEND, 32'h6);
    ent(IRQ_BASE + 1, 1'b1);
    rtn(IRQ_BASE + 1);
    ent(IRQ_BASE + 2, 1'b0);
    back(IRQ_BASE + 2);
    $display("test tail chain done");
    // disabled line stays pending and is not taken
    apb(1'b1, OFS_DISABLE, 32'h4);
    apb(1'b1, OFS_SET_PEND, 32'h4);
    repeat (10) @(posedge pclk);
    #1;
    check(32'(handler_mode), 32'h0);
    rd_chk(OFS_SET_PEND, 32'h4);
    apb(1'b1, OFS_CLR_PEND, 32'h4);
    $display("test disable done");
    // every fault and call source ends in hard fault while its handler is disabled
    lat <= 4'h1;
    apb(1'b1, OFS_CFG, 32'h1C);
    for (k = 0; k < 12; k++) begin
      @(posedge pclk);
      flt <= 12'h1 << k;
      @(posedge pclk);
      flt <= 12'h000;
      #1;
      check(32'(fetch_abort), 32'(k == 8));
      ent(EXC_HF, 1'b1);
      back(EXC_HF);
    end
    rd_chk(OFS_FAULT, 32'hF);
    apb(1'b1, OFS_HND_CTRL, 32'h1 << (HC_EN_LSB + 3));
    @(posedge pclk);
    flt[7] <= 1'b1;
    @(posedge pclk);
    flt[7] <= 1'b0;
    ent(EXC_SVC, 1'b1);
    back(EXC_SVC);
    $display("test faults done");
    // software pends, timer tick, debug monitor gated by halting
    apb(1'b1, OFS_HND_CTRL, 32'h0070_0000);
    apb(1'b1, OFS_CTRL_STATE, 32'h1 << CS_NMI_SET);
    ent(EXC_NMI, 1'b1);
    back(EXC_NMI);
    apb(1'b1, OFS_CTRL_STATE, 32'h1 << CS_PSV_SET);
    ent(EXC_PSV, 1'b1);
    back(EXC_PSV);
    apb(1'b1, OFS_CTRL_STATE, 32'h1 << CS_TICK_SET);
    ent(EXC_TICK, 1'b1);
    back(EXC_TICK);
    apb(1'b1, OFS_CFG, 32'h20);
    @(posedge pclk);
    tick_zero <= 1'b1;
    @(posedge pclk);
    tick_zero <= 1'b0;
    ent(EXC_TICK, 1'b1);
    back(EXC_TICK);
    // a request seen while halting must not pend
    halting <= 1'b1;
    dbg_req <= 1'b1;
    @(posedge pclk);
    dbg_req <= 1'b0;
    halting <= 1'b0;
    repeat (4) @(posedge pclk);
    #1;
    check(32'(handler_mode), 32'h0);
    @(posedge pclk);
    dbg_req <= 1'b1;
    @(posedge pclk);
    dbg_req <= 1'b0;
    ent(EXC_DBG, 1'b1);
    back(EXC_DBG);
    $display("test system handlers done");
    // two subpriority bits: level 0 may not preempt level 3
    apb(1'b1, OFS_PRIO0, 32'h0000_0300);
    apb(1'b1, OFS_CFG, 32'h2);
    apb(1'b1, OFS_SET_PEND, 32'h2);
    ent(IRQ_BASE + 1, 1'b1);
    apb(1'b1, OFS_SET_PEND, 32'h1);
    repeat (4) @(posedge pclk);
    rd_chk(OFS_ACTIVE, 32'h2);
    rtn(IRQ_BASE + 1);
    ent(IRQ_BASE, 1'b0);
    back(IRQ_BASE);
    $display("test subpriority done");
    stop_test();
  end
endmodule // exception_priority_model_tb
